// *** src/snf_core.sv ***
`timescale 1ns/1ps
module snf_core #(
    parameter int PROG_CYCLES = snf_pkg::PROG_CYC, // program busy count
    parameter int ERASE_CYCLES = snf_pkg::ERASE_CYC // erase busy count
) (
    input wire logic clk, // 100 MHz clock
    input wire logic rst_n, // async reset, power-up
    input wire snf_pkg::snf_link_s link_in, // raw pins
    input wire logic wp_n, // write-protect pin, raw
    output logic [3:0] io_out, // data out lanes
    output logic [3:0] io_oe, // data out enables
    output logic [1:0] drive_strength_select, // pad drive code
    output logic prog_strobe, // cache to array copy pulse
    output logic [snf_pkg::ADDR_BITS-1:0] prog_row, // copied row
    output logic [7:0] status_q // status mirror
);
    import snf_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [5:0] s1_reg, s2_reg, s1_next, s2_next;
    logic wp1_reg, wp2_reg, sck_d_reg;
    always_comb begin
        s1_next = {link_in.sck, link_in.cs_n, link_in.io};
        s2_next = s1_reg;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 6'h10;
            s2_reg <= 6'h10;
            wp1_reg <= 1'b0;
            wp2_reg <= 1'b0;
            sck_d_reg <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            wp1_reg <= wp_n;
            wp2_reg <= wp1_reg;
            sck_d_reg <= s2_reg[5];
        end
    end
    wire cs_n_s = s2_reg[4];
    wire [3:0] io_s = s2_reg[3:0];
    wire rise = s2_reg[5] & ~sck_d_reg & ~cs_n_s;
    wire fall = ~s2_reg[5] & sck_d_reg & ~cs_n_s;

    // ==========================================================
    // Frame decoder and registers
    // ==========================================================
    typedef enum logic [2:0] {S_OP, S_ADDR, S_DATA, S_FADDR, S_FDATA,
                              S_GET, S_DONE} snf_state_e;
    snf_state_e st_reg, st_next;
    logic [7:0] op_reg, op_next, sh_reg, sh_next, fa_reg, fa_next;
    logic [5:0] bit_reg, bit_next;
    logic [ADDR_BITS-1:0] adr_reg, adr_next;
    logic [COL_W-1:0] col_reg, col_next;
    logic [7:0] prot_reg, prot_next, conf_reg, conf_next;
    logic wlat_reg, wlat_next, pf_reg, pf_next, ef_reg, ef_next;
    logic busy_reg, busy_next;
    logic [BUSY_W-1:0] cnt_reg, cnt_next;
    logic [3:0] out_reg, out_next, oe_reg, oe_next;
    logic [7:0] gsh_reg, gsh_next;
    logic ps_reg, ps_next;
    logic [ADDR_BITS-1:0] prow_reg, prow_next;
    logic [12:0] fill_reg, fill_next;
    logic wr_en;
    logic [12:0] wr_idx;
    logic [7:0] wr_dat;
    logic [7:0] cache [0:CACHE_BYTES-1];

    function automatic logic [2:0] step(input snf_width_e w);
        step = (w == SNF_W4) ? 3'd4 : (w == SNF_W2) ? 3'd2 : 3'd1;
    endfunction

    function automatic snf_width_e op_width(input logic [7:0] op);
        if (op == OP_LOAD4 || op == OP_RAND4) op_width = SNF_W4;
        else if (op == OP_LOAD2 || op == OP_RAND2) op_width = SNF_W2;
        else op_width = SNF_W1;
    endfunction

    function automatic logic is_load(input logic [7:0] op);
        is_load = op == OP_LOAD1 || op == OP_RAND1 || op == OP_LOAD2 ||
                  op == OP_RAND2 || op == OP_LOAD4 || op == OP_RAND4;
    endfunction

    // Locked range: upper or lower 2^(bp-1) of 1024 blocks.
    function automatic logic locked(input logic [7:0] pr,
                                    input logic [BLK_W-1:0] blk);
        logic [3:0] rng;
        logic [BLK_W:0] n;
        rng = pr[PR_RNG_MSB:PR_RNG_LSB];
        n = 11'd1 << (rng - 4'd1);
        if (rng == 4'd0) locked = 1'b0;
        else if (rng > 4'hA) locked = 1'b1;
        else if (pr[PR_BOTTOM]) locked = {1'b0, blk} < n;
        else locked = {1'b0, blk} >= 11'd1024 - n;
    endfunction

    wire [7:0] stat = {4'h0, pf_reg, ef_reg, wlat_reg, busy_reg};
    wire [2:0] stp = step(op_width(op_reg));

    always_comb begin
        st_next = st_reg; op_next = op_reg; sh_next = sh_reg;
        fa_next = fa_reg; bit_next = bit_reg; adr_next = adr_reg;
        col_next = col_reg; prot_next = prot_reg; conf_next = conf_reg;
        wlat_next = wlat_reg; pf_next = pf_reg; ef_next = ef_reg;
        busy_next = busy_reg; cnt_next = cnt_reg; out_next = out_reg;
        oe_next = oe_reg; gsh_next = gsh_reg; ps_next = 1'b0;
        prow_next = prow_reg; fill_next = fill_reg;
        wr_en = 1'b0; wr_idx = col_reg; wr_dat = sh_reg;
        if (fill_reg != 13'd0) begin
            wr_en = 1'b1; wr_idx = fill_reg - 13'd1; wr_dat = FILL_BYTE;
            fill_next = fill_reg - 13'd1;
        end
        if (busy_reg) begin
            if (cnt_reg == '0) begin
                busy_next = 1'b0;
                wlat_next = 1'b0;
            end else cnt_next = cnt_reg - 1'b1;
        end
        if (cs_n_s) begin
            st_next = S_OP; bit_next = '0; oe_next = 4'h0;
        end else if (rise) begin
            case (st_reg)
                S_OP: begin
                    sh_next = {sh_reg[6:0], io_s[0]};
                    bit_next = bit_reg + 6'd1;
                    if (bit_reg == 6'd7) begin
                        op_next = {sh_reg[6:0], io_s[0]};
                        bit_next = '0;
                        st_next = S_DONE;
                        if (busy_reg) begin
                            if (op_next == OP_GETF) st_next = S_FADDR;
                        end else if (op_next == OP_WREN) wlat_next = 1'b1;
                        else if (op_next == OP_RESET)
                            conf_next = conf_reg & CONF_CFG_CLR;
                        else if (op_next == OP_GETF || op_next == OP_SETF)
                            st_next = S_FADDR;
                        else if (is_load(op_next) || op_next == OP_EXEC ||
                                 op_next == OP_ERASE) st_next = S_ADDR;
                    end
                end
                S_ADDR: begin
                    adr_next = {adr_reg[ADDR_BITS-2:0], io_s[0]};
                    bit_next = bit_reg + 6'd1;
                    // 16 address bits for a load
                    if (is_load(op_reg) && bit_reg == 6'd15) begin
                        col_next = adr_next[COL_W-1:0];
                        bit_next = '0; st_next = S_DATA;
                        if (op_reg == OP_LOAD1 || op_reg == OP_LOAD2 ||
                            op_reg == OP_LOAD4)
                            fill_next = 13'(CACHE_BYTES);
                    end else if (!is_load(op_reg) &&
                                 bit_reg == 6'(ADDR_BITS - 1)) begin
                        st_next = S_DONE;
                        if (wlat_reg) begin
                            busy_next = 1'b1;
                            if (op_reg == OP_EXEC) begin
                                cnt_next = BUSY_W'(PROG_CYCLES - 1);
                                pf_next = locked(prot_reg,
                                    adr_next[BLK_LSB +: BLK_W]);
                                ps_next = ~pf_next;
                                prow_next = adr_next;
                            end else begin
                                cnt_next = BUSY_W'(ERASE_CYCLES - 1);
                                ef_next = locked(prot_reg,
                                    adr_next[BLK_LSB +: BLK_W]);
                            end
                        end
                    end
                end
                S_DATA: begin
                    if (stp == 3'd4) sh_next = {sh_reg[3:0], io_s};
                    else if (stp == 3'd2) sh_next = {sh_reg[5:0], io_s[1:0]};
                    else sh_next = {sh_reg[6:0], io_s[0]};
                    bit_next = bit_reg + 6'(stp);
                    if (bit_reg + 6'(stp) == 6'd8) begin
                        bit_next = '0;
                        if (col_reg < 13'(CACHE_BYTES) && fill_reg == 0) begin
                            wr_en = 1'b1; wr_idx = col_reg; wr_dat = sh_next;
                        end
                        if (col_reg < 13'(CACHE_BYTES))
                            col_next = col_reg + 13'd1;
                    end
                end
                S_FADDR: begin
                    sh_next = {sh_reg[6:0], io_s[0]};
                    bit_next = bit_reg + 6'd1;
                    if (bit_reg == 6'd7) begin
                        fa_next = sh_next; bit_next = '0;
                        st_next = (op_reg == OP_GETF) ? S_GET : S_FDATA;
                        gsh_next = (sh_next == FA_PROT) ? prot_reg :
                                   (sh_next == FA_CONF) ? conf_reg :
                                   (sh_next == FA_STAT) ? stat : 8'h00;
                    end
                end
                S_FDATA: begin
                    sh_next = {sh_reg[6:0], io_s[0]};
                    bit_next = bit_reg + 6'd1;
                    if (bit_reg == 6'd7) begin
                        st_next = S_DONE;
                        if (fa_reg == FA_CONF) conf_next = sh_next;
                        else if (fa_reg == FA_PROT) begin
                            if (!prot_reg[PR_WPD] && prot_reg[PR_WR_DIS] &&
                                !wp2_reg)
                                prot_next = {prot_reg[7:2], sh_next[1:0]};
                            else prot_next = sh_next;
                        end
                    end
                end
                default: ;
            endcase
        end else if (fall && st_reg == S_GET) begin
            out_next = {2'b00, gsh_reg[7], 1'b0};
            oe_next = 4'h2;
            gsh_next = {gsh_reg[6:0], gsh_reg[7]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= S_OP; op_reg <= '0; sh_reg <= '0; fa_reg <= '0;
            bit_reg <= '0; adr_reg <= '0; col_reg <= '0;
            prot_reg <= PROT_PWRUP;
            conf_reg <= CONF_PWRUP;
            wlat_reg <= 1'b0; pf_reg <= 1'b0; ef_reg <= 1'b0;
            busy_reg <= 1'b0; cnt_reg <= '0; out_reg <= '0; oe_reg <= '0;
            gsh_reg <= '0; ps_reg <= 1'b0; prow_reg <= '0; fill_reg <= '0;
        end else begin
            st_reg <= st_next; op_reg <= op_next; sh_reg <= sh_next;
            fa_reg <= fa_next; bit_reg <= bit_next; adr_reg <= adr_next;
            col_reg <= col_next; prot_reg <= prot_next;
            conf_reg <= conf_next; wlat_reg <= wlat_next; pf_reg <= pf_next;
            ef_reg <= ef_next; busy_reg <= busy_next; cnt_reg <= cnt_next;
            out_reg <= out_next; oe_reg <= oe_next; gsh_reg <= gsh_next;
            ps_reg <= ps_next; prow_reg <= prow_next; fill_reg <= fill_next;
        end
    end

    // Cache memory has no reset; content is defined by the first plain load, whose fill writes FILL_BYTE to every byte.
    always_ff @(posedge clk) begin
        if (wr_en) cache[wr_idx] <= wr_dat;
    end

    logic [7:0] stq_reg;
    logic [1:0] ds_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stq_reg <= '0;
            ds_reg <= '0;
        end else begin
            stq_reg <= stat;
            ds_reg <= conf_reg[CF_DRV_LSB +: 2];
        end
    end
    assign io_out = out_reg;
    assign io_oe = oe_reg;
    assign drive_strength_select = ds_reg;
    assign prog_strobe = ps_reg;
    assign prog_row = prow_reg;
    assign status_q = stq_reg;

    // ==========================================================
    // Checks
    // ==========================================================
    a_erase_needs_latch: assert property (@(posedge clk)
        disable iff (!rst_n) $rose(busy_reg) |-> $past(wlat_reg))
        else $error("busy started without write enable latch");
    a_busy_clears_latch: assert property (@(posedge clk)
        disable iff (!rst_n) $fell(busy_reg) |-> !wlat_reg)
        else $error("latch still set after busy end");
    a_prot_frozen: assert property (@(posedge clk)
        disable iff (!rst_n) (!prot_reg[PR_WPD] && prot_reg[PR_WR_DIS] &&
        !wp2_reg) |=> prot_reg[7:2] == $past(prot_reg[7:2]))
        else $error("locked protection bits changed");
    a_reset_cfg: assert property (@(posedge clk)
        disable iff (!rst_n) (rise && st_reg == S_OP && bit_reg == 6'd7 &&
        !busy_reg && op_next == OP_RESET) |=> conf_reg[7:6] == 2'b00
        && conf_reg[1] == 1'b0 && prot_reg == $past(prot_reg))
        else $error("reset did not clear region select");
    a_prog_busy: assert property (@(posedge clk)
        disable iff (!rst_n) prog_strobe |-> busy_reg)
        else $error("program copy without busy");
    a_col_bound: assert property (@(posedge clk)
        disable iff (!rst_n) wr_en |-> wr_idx < 13'(CACHE_BYTES))
        else $error("cache write past end");
    sequence s_op_end_busy;
        rise && st_reg == S_OP && bit_reg == 6'd7 && busy_reg;
    endsequence
    a_busy_poll: assert property (@(posedge clk)
        disable iff (!rst_n) s_op_end_busy ##0 op_next == OP_GETF |=>
        st_reg == S_FADDR)
        else $error("status poll refused while busy");
endmodule

// *** src/snf_pkg.sv ***
package snf_pkg;
    // Opcodes.
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_LOAD1 = 8'h02;
    localparam logic [7:0] OP_RAND1 = 8'h84;
    localparam logic [7:0] OP_LOAD2 = 8'hA2;
    localparam logic [7:0] OP_RAND2 = 8'h44;
    localparam logic [7:0] OP_LOAD4 = 8'h32;
    localparam logic [7:0] OP_RAND4 = 8'h34;
    localparam logic [7:0] OP_EXEC = 8'h10;
    localparam logic [7:0] OP_ERASE = 8'hD8;
    localparam logic [7:0] OP_GETF = 8'h0F;
    localparam logic [7:0] OP_SETF = 8'h1F;
    localparam logic [7:0] OP_RESET = 8'hFF;
    // Feature register addresses.
    localparam logic [7:0] FA_PROT = 8'hA0;
    localparam logic [7:0] FA_CONF = 8'hB0;
    localparam logic [7:0] FA_STAT = 8'hC0;
    // Geometry.
    localparam int CACHE_BYTES = 4352;
    localparam int COL_W = 13;
    localparam int ADDR_BITS = 24;
    localparam int BLK_LSB = 6;
    localparam int BLK_W = 10;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    // Block protection register fields.
    localparam int PR_WR_DIS = 7;
    localparam int PR_RNG_MSB = 6;
    localparam int PR_RNG_LSB = 3;
    localparam int PR_BOTTOM = 2;
    localparam int PR_WPD = 1;
    localparam logic [7:0] PROT_PWRUP = 8'h7C;
    localparam logic [5:0] PROT_LOCK_MASK = 6'h3F;
    // Configuration register fields and reset clear mask.
    localparam logic [7:0] CONF_PWRUP = 8'h00;
    localparam logic [7:0] CONF_CFG_CLR = 8'h3D;
    localparam int CF_DRV_LSB = 2;
    // Status bit positions.
    localparam int ST_PFAIL = 3;
    localparam int ST_EFAIL = 2;
    localparam int ST_LATCH = 1;
    localparam int ST_BUSY = 0;
    // Busy times, microseconds, and the clock rate.
    localparam int CLK_MHZ = 100;
    localparam int PROG_US = 200;
    localparam int ERASE_US = 2000;
    localparam int PROG_CYC = PROG_US * CLK_MHZ;
    localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
    localparam int BUSY_W = 20;

    typedef enum logic [1:0] {SNF_W1, SNF_W2, SNF_W4} snf_width_e;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic [3:0] io;
    } snf_link_s;
endpackage

// *** verif/snf_host_model.sv ***
`timescale 1ns/1ps
module snf_host_model (
    input wire logic clk, // bench clock
    input wire logic [3:0] io_out, // device data lanes
    input wire logic [3:0] io_oe, // device lane enables
    output snf_pkg::snf_link_s link // pins toward the device
);
    import snf_pkg::*;

    initial link = '{sck: 1'b0, cs_n: 1'b1, io: 4'hA};

    // Half a serial clock period is four system clocks, 80 ns a bit.
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic start();
        @(posedge clk);
        #1;
        link.cs_n = 1'b0;
        half();
    endtask

    // The serial clock stands low between frames; released lanes flip.
    task automatic stop();
        half();
        link.cs_n = 1'b1;
        link.io = ~link.io;
        half();
    endtask

    task automatic send(input logic [7:0] b, input int w);
        int n;
        for (n = 8 - w; n >= 0; n = n - w) begin
            link.io = 4'((b >> n) & ((1 << w) - 1));
            half();
            link.sck = 1'b1;
            half();
            link.sck = 1'b0;
        end
    endtask

    // An undriven answer lane reads as unknown so it can never match.
    task automatic recv(output logic [7:0] b);
        int i;
        for (i = 7; i >= 0; i--) begin
            link.io = ~link.io;
            half();
            link.sck = 1'b1;
            b[i] = io_oe[1] ? io_out[1] : 1'bx;
            half();
            link.sck = 1'b0;
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                       input int nb);
        int k;
        start();
        send(op, 1);
        for (k = nb - 1; k >= 0; k--) begin
            send(a[8*k+:8], 1);
        end
        stop();
    endtask

    task automatic setf(input logic [7:0] fa, input logic [7:0] d);
        cmd(OP_SETF, {8'h00, fa, d}, 2);
    endtask

    task automatic getf(input logic [7:0] fa, output logic [7:0] d);
        start();
        send(OP_GETF, 1);
        send(fa, 1);
        recv(d);
        stop();
    endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import snf_pkg::*;
    localparam int PROG_N = 400;
    localparam int ERASE_N = 600;
    logic clk, rst_n, wp_n;
    snf_link_s host_link, dut_link;
    logic [3:0] io_out, io_oe;
    logic [1:0] ds;
    logic prog_strobe;
    logic [ADDR_BITS-1:0] prog_row, last_row, row;
    logic [7:0] status_q, rd, val;
    logic [7:0] ops [6] = '{OP_LOAD1, OP_RAND1, OP_LOAD2, OP_RAND2,
                            OP_LOAD4, OP_RAND4};
    int wid [6] = '{1, 1, 2, 2, 4, 4};
    int fail_count = 0, checks = 0, strobes = 0, cycles = 0;
    int i, s0, blk;
    logic [3:0] prange;
    logic from_bot, lk;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // The shared answer lane carries whoever is enabled on it.
    always_comb begin
        dut_link = host_link;
        dut_link.io = (io_oe & io_out) | (~io_oe & host_link.io);
    end

    always @(posedge clk) begin
        cycles++;
        if (prog_strobe === 1'b1) begin
            strobes++;
            last_row = prog_row;
        end
        if (cycles == 90000) begin
            fail_count++;
            $display("MISMATCH t=%0t run did not finish", $time);
            close_out();
        end
    end

    snf_core #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) DUT (
        .clk(clk), .rst_n(rst_n), .link_in(dut_link), .wp_n(wp_n),
        .io_out(io_out), .io_oe(io_oe), .drive_strength_select(ds),
        .prog_strobe(prog_strobe), .prog_row(prog_row),
        .status_q(status_q));

    snf_host_model host (.clk(clk), .io_out(io_out), .io_oe(io_oe),
                         .link(host_link));

    task automatic close_out();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic getchk(input logic [7:0] fa, input logic [7:0] exp);
        host.getf(fa, rd);
        chk(32'(rd), 32'(exp), "feature read");
    endtask

    task automatic wait_ready();
        int n;
        rd = 8'h01;
        for (n = 0; n < 40 && rd[0] !== 1'b0; n++) begin
            host.getf(FA_STAT, rd);
        end
    endtask

    // The plain loads' fill runs first, so their data waits it out.
    task automatic load(input logic [7:0] op, input int w);
        int k;
        host.start();
        host.send(op, 1);
        host.send({3'b000, 5'($urandom)}, 1);
        host.send(8'($urandom), 1);
        if (op == OP_LOAD1 || op == OP_LOAD2 || op == OP_LOAD4) begin
            repeat (4400) @(posedge clk);
            #1;
        end
        for (k = 0; k < 1 + $urandom % 4; k++) begin
            host.send(8'($urandom), w);
        end
        host.stop();
    endtask

    function automatic logic locked(logic [3:0] p, logic t, int b);
        int n;
        if (p == 4'h0) return 1'b0;
        if (p > 4'hA) return 1'b1;
        n = 1 << (p - 1);
        return t ? (b < n) : (b >= 1024 - n);
    endfunction

    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        void'($urandom(40130));
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        getchk(FA_PROT, 8'h7C);
        getchk(FA_CONF, 8'h00);
        chk(32'(ds), 32'h0, "drive code");
        host.cmd(OP_ERASE, 24'h000040, 3);
        getchk(FA_STAT, 8'h00);
        host.setf(FA_STAT, 8'hFF);
        getchk(FA_STAT, 8'h00);
        host.cmd(OP_WREN, 24'h0, 0);
        getchk(FA_STAT, 8'h02);
        chk(32'(status_q), 32'h02, "status mirror");
        host.setf(FA_PROT, 8'h80);
        wp_n = 1'b0;
        host.setf(FA_PROT, 8'h7C);
        getchk(FA_PROT, 8'h80);
        wp_n = 1'b1;
        host.setf(FA_PROT, 8'h28);
        getchk(FA_PROT, 8'h28);
        // Lock tight stays off, so the protection bits remain writable.
        val = 8'($urandom) & 8'hDF;
        host.setf(FA_CONF, val);
        getchk(FA_CONF, val);
        chk(32'(ds), 32'(val[3:2]), "drive code");
        host.cmd(OP_RESET, 24'h0, 0);
        wait_ready();
        getchk(FA_CONF, val & 8'h3D);
        chk(32'(ds), 32'(val[3:2]), "drive code");
        getchk(FA_PROT, 8'h28);
        for (i = 0; i < 12; i++) begin
            prange = (i < 2) ? 4'h1 : 4'($urandom);
            from_bot = (i < 2) ? 1'b0 : 1'($urandom);
            blk = (i == 0) ? 1023 : (i == 1) ? 1022 : $urandom % 1024;
            lk = locked(prange, from_bot, blk);
            row = {8'h00, 10'(blk), 6'($urandom)};
            host.setf(FA_PROT, {1'b0, prange, from_bot, 2'b00});
            host.cmd(OP_WREN, 24'h0, 0);
            s0 = strobes;
            if (i < 6) begin
                load(ops[i], wid[i]);
                // Each of the first six iterations programs its page only once.
                host.cmd(OP_EXEC, row, 3);
            end else begin
                host.cmd(OP_ERASE, row, 3);
            end
            host.getf(FA_STAT, rd);
            chk(32'(rd[1:0]), 32'h3, "busy with latch");
            wait_ready();
            chk(32'({i < 6 ? rd[3] : rd[2], rd[1:0]}), 32'({lk, 2'b00}),
                "end status");
            chk(32'({i < 6 ? status_q[3] : status_q[2], status_q[1:0]}),
                32'({lk, 2'b00}), "status mirror");
            if (i < 6 && !lk) begin
                chk(32'(strobes - s0), 32'h1, "copy pulses");
                chk(32'(last_row), 32'(row), "copied row");
            end
        end
        close_out();
    end
endmodule
